// file: src/pin_sync.sv
// Purpose: Two-flop synchroniser bank for pins that arrive from outside the clock domain.
// Assumes: Each bit is an independent level; no bus coherency is promised.
// Notes:   The first rank is read only by the second rank.
`timescale 1ns/1ps

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } sync_state_t;

  sync_state_t q;
  sync_state_t n;

  always_comb begin
    n      = q;
    n.meta = i_async;
    n.out  = q.meta;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_sync = q.out;

endmodule

// file: src/xpt_map.svh
// Purpose: Offsets, field positions and reset values of the crosspoint programming block.
// Assumes: Included by its bare name wherever these constants are needed.
// Notes:   Register offsets are byte addresses on the AHB-Lite slave, one word each.
`ifndef XPT_MAP_SVH
`define XPT_MAP_SVH

`define XPT_OUTPUTS      16
`define XPT_SLOT_W       5
`define XPT_RANK_W       80
`define XPT_SEL_W        4
`define XPT_EN_POS       4

`define XPT_ADDR_W       8
`define XPT_OFF_CTRL     8'h00
`define XPT_OFF_RANK1_0  8'h04
`define XPT_OFF_RANK1_1  8'h08
`define XPT_OFF_RANK1_2  8'h0C
`define XPT_OFF_RANK2_0  8'h10
`define XPT_OFF_RANK2_1  8'h14
`define XPT_OFF_RANK2_2  8'h18
`define XPT_OFF_PINS     8'h1C

`define XPT_CTRL_LOAD_EN 0
`define XPT_CTRL_RESET   1'h1

`define XPT_SYNC_W       31
`define XPT_HRESP_OKAY   1'h0

`endif

// file: src/xpt_pkg.sv
// Purpose: Types shared by the crosspoint programming block.
// Assumes: xpt_map.svh supplies the widths.
// Notes:   The whole state of the top module is one packed struct.
`include "xpt_map.svh"

package xpt_pkg;

  typedef logic [`XPT_RANK_W-1:0] rank_t;
  typedef logic [`XPT_SLOT_W-1:0] slot_t;

  typedef struct packed {
    rank_t                    rank1;
    rank_t                    rank2;
    logic                     clk_prev;
    logic                     load_en;
    logic [`XPT_OUTPUTS-1:0]  out;
    logic [`XPT_OUTPUTS-1:0]  oe;
    logic [31:0]              hrdata;
    logic                     hready;
    logic                     wr_pend;
    logic [`XPT_ADDR_W-1:0]   wr_addr;
  } xpt_state_t;

endpackage

// file: src/xpt_prog.sv
// Purpose: Programming logic of a 16x16 crosspoint switch with an AHB-Lite status port.
// Assumes: Pin inputs are asynchronous; pin clock high and low last well over 2 cycles.
// Notes:   Pin edges are seen about three system cycles after they happen.
// Function
// - Clock edges are ignored and state held unless chip enable is low.
// - First-rank register loads only on a falling edge of the pin clock.
// - Load style select low means serial loading, high means parallel.
// - Serial mode with enables met shifts the serial input into 80 bits.
// - Serial output shows the bit shifted in 79 edges before the latest shift.
// - Parallel mode writes five data bits into the addressed 5-bit slot.
// - Chip enable and update low with reset high make the second rank transparent.
// - Update high holds the second rank so loading never reaches the array.
// - Reset pin low disables all outputs, leaving register state unchanged.
// - Output address bit0 is least significant, bit3 most significant.
// - Slot select bits pick one of 16 inputs, bit0 least significant.
// - Fifth slot bit enables its output, driving the selected input.
// - Sixteen inputs and outputs numbered 0 to 15, one slot each.
// - In each serial slot the four select bits precede the enable bit.
`timescale 1ns/1ps
`include "xpt_map.svh"

module xpt_prog
  import xpt_pkg::*;
(
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_hsel,
  input  wire logic [31:0]             i_haddr,
  input  wire logic [1:0]              i_htrans,
  input  wire logic                    i_hwrite,
  input  wire logic [2:0]              i_hsize,
  input  wire logic [31:0]             i_hwdata,
  input  wire logic                    i_hready,
  output logic                         o_hreadyout,
  output logic                         o_hresp,
  output logic [31:0]                  o_hrdata,
  input  wire logic                    i_chip_en_n,
  input  wire logic                    i_pin_clk,
  input  wire logic                    i_serial_in,
  output logic                         o_serial_out,
  input  wire logic                    i_update_n,
  input  wire logic                    i_outputs_off_n,
  input  wire logic                    i_load_style_select,
  input  wire logic                    i_out_addr_bit0,
  input  wire logic                    i_out_addr_bit1,
  input  wire logic                    i_out_addr_bit2,
  input  wire logic                    i_out_addr_bit3,
  input  wire logic                    i_src_sel_bit0,
  input  wire logic                    i_src_sel_bit1,
  input  wire logic                    i_src_sel_bit2,
  input  wire logic                    i_src_sel_bit3,
  input  wire logic                    i_output_on_bit,
  input  wire logic [`XPT_OUTPUTS-1:0] i_signal_inputs,
  output logic [`XPT_OUTPUTS-1:0]      o_signal_outputs,
  output logic [`XPT_OUTPUTS-1:0]      o_signal_outputs_oe
);

  // Slot k sits at bits 5k+4..5k: D0 at the top, since it is shifted in first, enable at 5k.
  function automatic slot_t slot_get(input rank_t v, input logic [3:0] k);
    int b;
    b = int'(k) * `XPT_SLOT_W;
    slot_get = {v[b], v[b+1], v[b+2], v[b+3], v[b+4]};
  endfunction

  function automatic rank_t slot_put(input rank_t v, input logic [3:0] k, input slot_t d);
    int    b;
    rank_t r;
    b      = int'(k) * `XPT_SLOT_W;
    r      = v;
    r[b+4] = d[0];
    r[b+3] = d[1];
    r[b+2] = d[2];
    r[b+1] = d[3];
    r[b]   = d[`XPT_EN_POS];
    slot_put = r;
  endfunction

  function automatic logic [31:0] rank_word(input rank_t v, input logic [1:0] w);
    case (w)
      2'h0:    rank_word = v[31:0];
      2'h1:    rank_word = v[63:32];
      2'h2:    rank_word = {16'h0000, v[79:64]};
      default: rank_word = 32'h0000_0000;
    endcase
  endfunction

  // Gathers the enable bit of each slot, which sits at the bottom of its five bits.
  function automatic logic [`XPT_OUTPUTS-1:0] rank_enables(input rank_t v);
    logic [`XPT_OUTPUTS-1:0] e;
    e = '0;
    for (int k = 0; k < `XPT_OUTPUTS; k++) begin
      e[k] = v[k*`XPT_SLOT_W];
    end
    rank_enables = e;
  endfunction

  // Marks the five bits of slot k, so checks can see that the other slots stay put.
  function automatic rank_t slot_mask(input logic [3:0] k);
    slot_mask = rank_t'({`XPT_SLOT_W{1'b1}}) << (int'(k) * `XPT_SLOT_W);
  endfunction

  xpt_state_t q;
  xpt_state_t n;

  logic [`XPT_SYNC_W-1:0]  sync_w;
  logic                    ce_n_s;
  logic                    pclk_s;
  logic                    sin_s;
  logic                    upd_n_s;
  logic                    on_n_s;
  logic                    load_style_select_s;
  logic [3:0]              addr_s;
  slot_t                   data_s;
  logic [`XPT_OUTPUTS-1:0] in_s;
  logic                    fall;
  logic                    load_ok;
  logic                    load_ser;
  logic                    load_par;
  logic                    transp;
  logic                    addr_ph;

  pin_sync #(
    .W (`XPT_SYNC_W)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_async   ({i_signal_inputs, i_output_on_bit, i_src_sel_bit3, i_src_sel_bit2,
                 i_src_sel_bit1, i_src_sel_bit0, i_out_addr_bit3, i_out_addr_bit2,
                 i_out_addr_bit1, i_out_addr_bit0, i_load_style_select, i_outputs_off_n,
                 i_update_n, i_serial_in, i_pin_clk, i_chip_en_n}),
    .o_sync    (sync_w)
  );

  assign ce_n_s    = sync_w[0];
  assign pclk_s    = sync_w[1];
  assign sin_s     = sync_w[2];
  assign upd_n_s   = sync_w[3];
  assign on_n_s    = sync_w[4];
  assign load_style_select_s = sync_w[5];
  assign addr_s    = sync_w[9:6];
  assign data_s    = sync_w[14:10];
  assign in_s      = sync_w[30:15];

  // The data pins pass the same two flops as the clock, so they are read in the fall cycle.
  assign fall     = q.clk_prev & ~pclk_s;
  assign load_ok  = fall & ~ce_n_s & upd_n_s & on_n_s & q.load_en;
  assign load_ser = load_ok & ~load_style_select_s;
  assign load_par = load_ok & load_style_select_s;
  assign transp   = ~ce_n_s & ~upd_n_s & on_n_s;
  assign addr_ph  = i_hsel & i_hready & i_htrans[1];

  always_comb begin
    slot_t sl;
    sl         = '0;
    n          = q;
    n.clk_prev = pclk_s;
    n.hready   = 1'b1;
    n.wr_pend  = 1'b0;

    if (load_ser) begin
      n.rank1 = {q.rank1[`XPT_RANK_W-2:0], sin_s};
    end else if (load_par) begin
      n.rank1 = slot_put(q.rank1, addr_s, data_s);
    end

    // The second rank follows the first one cycle later while transparent.
    if (transp) begin
      n.rank2 = q.rank1;
    end

    for (int k = 0; k < `XPT_OUTPUTS; k++) begin
      sl       = slot_get(q.rank2, 4'(k));
      n.oe[k]  = on_n_s & sl[`XPT_EN_POS];
      n.out[k] = sl[`XPT_EN_POS] & in_s[sl[3:0]];
    end

    if (q.wr_pend && q.wr_addr == `XPT_OFF_CTRL) begin
      n.load_en = i_hwdata[`XPT_CTRL_LOAD_EN];
    end

    if (addr_ph) begin
      if (i_hwrite) begin
        n.wr_pend = 1'b1;
        n.wr_addr = i_haddr[`XPT_ADDR_W-1:0];
      end else begin
        case (i_haddr[`XPT_ADDR_W-1:0])
          `XPT_OFF_CTRL:    n.hrdata = {31'h0000_0000, q.load_en};
          `XPT_OFF_RANK1_0: n.hrdata = rank_word(q.rank1, 2'h0);
          `XPT_OFF_RANK1_1: n.hrdata = rank_word(q.rank1, 2'h1);
          `XPT_OFF_RANK1_2: n.hrdata = rank_word(q.rank1, 2'h2);
          `XPT_OFF_RANK2_0: n.hrdata = rank_word(q.rank2, 2'h0);
          `XPT_OFF_RANK2_1: n.hrdata = rank_word(q.rank2, 2'h1);
          `XPT_OFF_RANK2_2: n.hrdata = rank_word(q.rank2, 2'h2);
          `XPT_OFF_PINS:    n.hrdata = {26'h000_0000, load_style_select_s, on_n_s, upd_n_s,
                                        sin_s, pclk_s, ce_n_s};
          default:          n.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // The pin reset gates the outputs and blocks loading; the system reset clears everything but load_en and hready, which it sets.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q         <= '0;
      q.load_en <= `XPT_CTRL_RESET;
      // An idle slave keeps hreadyout high through reset, so the bus never sees a stall.
      q.hready  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign o_hreadyout         = q.hready;
  assign o_hresp             = `XPT_HRESP_OKAY;
  assign o_hrdata            = q.hrdata;
  assign o_serial_out        = q.rank1[`XPT_RANK_W-1];
  assign o_signal_outputs    = q.out;
  assign o_signal_outputs_oe = q.oe;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  a_ce_blocks_load: assert property (ce_n_s |=> $stable(q.rank1))
    else $error("first rank changed with chip enable high");

  a_fall_only_load: assert property (!fall |=> $stable(q.rank1))
    else $error("first rank changed without a falling pin clock");

  a_serial_shift: assert property (
    load_ser |=> q.rank1 == {$past(q.rank1[`XPT_RANK_W-2:0]), $past(sin_s)})
    else $error("serial shift did not take the serial input");

  a_serial_out_age: assert property (
    load_ser |=> o_serial_out == $past(q.rank1[`XPT_RANK_W-2]))
    else $error("serial output does not show the aged bit");

  a_parallel_slot: assert property (
    load_par |=> slot_get(q.rank1, $past(addr_s)) == $past(data_s))
    else $error("parallel write missed the addressed slot");

  a_latch_transp: assert property (transp |=> q.rank2 == $past(q.rank1))
    else $error("second rank not transparent");

  a_update_hold: assert property (upd_n_s |=> $stable(q.rank2))
    else $error("second rank moved while update was high");

  a_reset_off: assert property (
    !on_n_s |=> o_signal_outputs_oe == '0 && $stable(q.rank1))
    else $error("pin reset did not disable outputs or disturbed state");

  a_slot0_route: assert property (
    on_n_s && q.rank2[0] |=> o_signal_outputs_oe[0] &&
      o_signal_outputs[0] == $past(in_s[{q.rank2[1], q.rank2[2], q.rank2[3], q.rank2[4]}]))
    else $error("output zero not routed from its selected input");

  a_off_no_input: assert property (
    !q.rank2[`XPT_SLOT_W] |=> !o_signal_outputs_oe[1] && !o_signal_outputs[1])
    else $error("disabled output one still carries an input");

  a_ahb_zero_wait: assert property (o_hreadyout && o_hresp == `XPT_HRESP_OKAY)
    else $error("slave inserted a wait or an error response");

  a_ce_holds_rank2: assert property (ce_n_s |=> $stable(q.rank2))
    else $error("second rank moved with chip enable high");

  a_ce_quiet_sout: assert property (ce_n_s |=> $stable(o_serial_out))
    else $error("serial output moved with chip enable high");

  a_upd_low_hold: assert property (!upd_n_s |=> $stable(q.rank1))
    else $error("first rank loaded while update was low");

  a_par_others_kept: assert property (
    load_par |=> ((q.rank1 ^ $past(q.rank1)) & ~slot_mask($past(addr_s))) == '0)
    else $error("parallel write disturbed another slot");

  a_sout_steady: assert property (!load_ok |=> $stable(o_serial_out))
    else $error("serial output moved without a load");

  a_reset_no_xfer: assert property (!on_n_s |=> $stable(q.rank2))
    else $error("second rank moved while the pin reset was low");

  a_oe_from_rank2: assert property (
    on_n_s |=> o_signal_outputs_oe == $past(rank_enables(q.rank2)))
    else $error("output enables do not follow the second rank");

  a_disabled_quiet: assert property (
    i_reset_n |=> (o_signal_outputs & ~$past(rank_enables(q.rank2))) == '0)
    else $error("a disabled output carries an input");

  a_slot15_route: assert property (
    on_n_s && q.rank2[75] |=> o_signal_outputs_oe[15] &&
      o_signal_outputs[15] == $past(in_s[{q.rank2[76], q.rank2[77], q.rank2[78], q.rank2[79]}]))
    else $error("output fifteen not routed from its selected input");

  a_gate_blocks_load: assert property (!q.load_en |=> $stable(q.rank1))
    else $error("first rank loaded while pin loading was gated");

  a_hrdata_kept: assert property (!(addr_ph && !i_hwrite) |=> $stable(o_hrdata))
    else $error("read data moved outside a read address phase");

endmodule

// file: test/xpt_pin_master.sv
// Purpose: Controller model that drives the programming pins of the crosspoint block.
// Assumes: Tasks are called just after a rising system edge; pins change by NBA on edges.
// Notes:   Data lines flip once their hold time is over, so stale values are never trusted.
`timescale 1ns/1ps

module xpt_pin_master (
  input  wire logic       i_clk_sys,
  output logic            o_chip_en_n,
  output logic            o_pin_clk,
  output logic            o_serial_in,
  output logic            o_update_n,
  output logic            o_outputs_off_n,
  output logic            o_load_style_select,
  output logic [3:0]      o_out_addr,
  output logic [3:0]      o_src_sel,
  output logic            o_output_on_bit
);
  initial begin
    o_chip_en_n = 1'h1;
    o_pin_clk = 1'h0;
    o_serial_in = 1'h0;
    o_update_n = 1'h1;
    o_outputs_off_n = 1'h1;
    o_load_style_select = 1'h0;
    o_out_addr = 4'h0;
    o_src_sel = 4'h0;
    o_output_on_bit = 1'h0;
  end

  task automatic set_ctl(input logic ce_n, input logic upd_n, input logic off_n);
    @(posedge i_clk_sys);
    o_chip_en_n <= ce_n;
    o_update_n <= upd_n;
    o_outputs_off_n <= off_n;
  endtask

  // A random half period makes the controller sometimes prompt, sometimes slow.
  task automatic pulse(input logic ser, input logic sin, input logic [3:0] a,
                       input logic [3:0] sel, input logic en);
    int half;
    half = 5 + int'($urandom % 4);
    @(posedge i_clk_sys);
    o_load_style_select <= ser;
    o_serial_in <= sin;
    o_out_addr <= a;
    o_src_sel <= sel;
    o_output_on_bit <= en;
    o_pin_clk <= 1'h1;
    repeat (half) @(posedge i_clk_sys);
    o_pin_clk <= 1'h0;
    repeat (half) @(posedge i_clk_sys);
    o_serial_in <= ~sin;
    o_src_sel <= ~sel;
    o_output_on_bit <= ~en;
  endtask
endmodule

// file: test/xpt_prog_tb_top.sv
// Purpose: Self-checking bench for the crosspoint programming block against a rank model.
// Assumes: One AHB-Lite slave, so its hreadyout is fed back as hready.
// Notes:   Pin paths are synchronised, so checks wait a few cycles after each pin change.
`timescale 1ns/1ps

module xpt_prog_tb_top;
  import xpt_pkg::*;
  logic        clk_sys, reset_n, hwrite, hreadyout, ce_n, pclk, sin, sout, upd_n, off_n;
  logic        load_style_select, on_bit, hresp;
  logic [1:0]  htrans;
  logic [3:0]  addr, sel;
  logic [15:0] sig_in, sig_out, sig_oe;
  logic [31:0] haddr, hwdata, hrdata, w;
  rank_t       r1_m, r2_m, v;
  int          fail_count, checks_done, cycles, a;
  logic [3:0]  s;
  logic        b;

  xpt_prog xpt_prog_i (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_hsel(1'h1),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_chip_en_n(ce_n), .i_pin_clk(pclk), .i_serial_in(sin),
    .o_serial_out(sout), .i_update_n(upd_n), .i_outputs_off_n(off_n),
    .i_load_style_select(load_style_select), .i_out_addr_bit0(addr[0]), .i_out_addr_bit1(addr[1]),
    .i_out_addr_bit2(addr[2]), .i_out_addr_bit3(addr[3]), .i_src_sel_bit0(sel[0]),
    .i_src_sel_bit1(sel[1]), .i_src_sel_bit2(sel[2]), .i_src_sel_bit3(sel[3]),
    .i_output_on_bit(on_bit), .i_signal_inputs(sig_in), .o_signal_outputs(sig_out),
    .o_signal_outputs_oe(sig_oe));

  xpt_pin_master xpt_pin_master_i (.i_clk_sys(clk_sys), .o_chip_en_n(ce_n),
    .o_pin_clk(pclk), .o_serial_in(sin), .o_update_n(upd_n), .o_outputs_off_n(off_n),
    .o_load_style_select(load_style_select), .o_out_addr(addr), .o_src_sel(sel),
    .o_output_on_bit(on_bit));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'h1);
    w = hrdata;
    chk("hresp", 80'h0, 80'(hresp));
  endtask

  task automatic rd_rank(input logic [7:0] base, output rank_t r);
    ahb(1'h0, base, 32'h0);
    r[31:0] = w;
    ahb(1'h0, base + 8'h04, 32'h0);
    r[63:32] = w;
    ahb(1'h0, base + 8'h08, 32'h0);
    r[79:64] = w[15:0];
  endtask

  // Expected switch outputs come from the second-rank model and the live inputs.
  task automatic chk_out();
    logic [15:0] eo, eoe;
    for (int k = 0; k < 16; k++) begin
      eoe[k] = r2_m[5*k];
      eo[k] = r2_m[5*k] & sig_in[{r2_m[5*k+1], r2_m[5*k+2], r2_m[5*k+3], r2_m[5*k+4]}];
    end
    chk("oe", 80'(eoe), 80'(sig_oe));
    chk("out", 80'(eo), 80'(sig_out));
  endtask

  task automatic apply_update();
    xpt_pin_master_i.set_ctl(1'h0, 1'h0, 1'h1);
    r2_m = r1_m;
    repeat (10) @(posedge clk_sys);
    chk_out();
    xpt_pin_master_i.set_ctl(1'h0, 1'h1, 1'h1);
  endtask

  initial begin
    reset_n = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    sig_in = 16'h0;
    r1_m = '0;
    r2_m = '0;
    void'($urandom(32'hBDF6));
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'h1;
    sig_in <= 16'($urandom);
    xpt_pin_master_i.set_ctl(1'h0, 1'h1, 1'h1);
    repeat (4) @(posedge clk_sys);
    for (int j = 0; j < 160; j++) begin
      b = 1'($urandom);
      xpt_pin_master_i.pulse(1'h0, b, 4'h0, 4'h0, 1'h0);
      r1_m = {r1_m[78:0], b};
      @(posedge clk_sys);
      chk("sout", 80'(r1_m[79]), 80'(sout));
    end
    rd_rank(8'h04, v);
    chk("rank1", r1_m, v);
    chk_out();
    apply_update();
    rd_rank(8'h10, v);
    chk("rank2", r2_m, v);
    for (int n = 0; n < 6; n++) begin
      a = (n == 0) ? 0 : (n == 1) ? 15 : int'($urandom % 16);
      s = 4'($urandom);
      // Output zero is switched on once so its routing is really exercised.
      b = (n == 0) ? 1'h1 : 1'($urandom);
      xpt_pin_master_i.pulse(1'h1, 1'h0, 4'(a), s, b);
      r1_m[5*a+4 -: 5] = {s[0], s[1], s[2], s[3], b};
    end
    rd_rank(8'h04, v);
    chk("rank1 par", r1_m, v);
    chk_out();
    xpt_pin_master_i.set_ctl(1'h1, 1'h0, 1'h1);
    xpt_pin_master_i.pulse(1'h1, 1'h0, 4'h3, 4'hA, 1'h1);
    repeat (10) @(posedge clk_sys);
    rd_rank(8'h04, v);
    chk("rank1 ce off", r1_m, v);
    chk_out();
    apply_update();
    xpt_pin_master_i.set_ctl(1'h0, 1'h0, 1'h0);
    repeat (10) @(posedge clk_sys);
    chk("oe off", 80'h0, 80'(sig_oe));
    rd_rank(8'h04, v);
    chk("rank1 kept", r1_m, v);
    apply_update();
    ahb(1'h1, 8'h00, 32'h0);
    ahb(1'h0, 8'h00, 32'h0);
    chk("ctrl", 80'h0, 80'(w));
    xpt_pin_master_i.pulse(1'h1, 1'h0, 4'h5, 4'h3, 1'h1);
    repeat (10) @(posedge clk_sys);
    rd_rank(8'h04, v);
    chk("rank1 gated", r1_m, v);
    ahb(1'h1, 8'h00, 32'h1);
    ahb(1'h0, 8'h1C, 32'h0);
    chk("pins", 80'h3C, 80'(w));
    ahb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 80'h0, 80'(w));
    conclude();
  end
endmodule
